// ==== verilog/timer8_defs.vh ====
// constants of the dual 8-bit timer/event counter block
// assumes a 16-bit byte address space reached by 8-bit load and store strobes
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define TMR_ADDR_CKS0   16'hFF6A
`define TMR_ADDR_CKS1   16'hEE8C
`define TMR_ADDR_CMP0   16'hFF17
`define TMR_ADDR_CMP1   16'hFF41
`define TMR_ADDR_MODE0  16'hFF6B
`define TMR_ADDR_MODE1  16'hFF43
`define TMR_ADDR_CNT0   16'hFF16
`define TMR_ADDR_CNT1   16'hFF1F
`define TMR_ADDR_PDIR1  16'hFF21
`define TMR_ADDR_PDIR3  16'hFF23
`define TMR_ADDR_PLAT1  16'hFF01
`define TMR_ADDR_PLAT3  16'hFF03

// ****************************************************************
// field positions
// ****************************************************************
`define TMR_RUN_BIT     7
`define TMR_PWM_BIT     6
`define TMR_PSET_HI_BIT 3
`define TMR_PSET_LO_BIT 2
`define TMR_TOGPOL_BIT  1
`define TMR_OEN_BIT     0
`define TMR_CKS_MSB     2
`define TMR_PIN0_BIT    7
`define TMR_PIN1_BIT    3
`define TMR_MODE_RMASK  8'hC3
`define TMR_PDIR3_FIXED 8'hF0

// ****************************************************************
// reset values
// ****************************************************************
`define TMR_RST_CKS     3'h0
`define TMR_RST_MODE    8'h00
`define TMR_RST_CMP     8'h00
`define TMR_RST_CNT     8'h00
`define TMR_RST_PDIR    8'hFF
`define TMR_RST_PLAT    8'h00
`define TMR_RST_MODEB   4'h0
`define TMR_RST_PDIR3   4'hF
`define TMR_RST_PLAT3   4'h0

// ****************************************************************
// clock select codes and prescaler exponents (divide by 2**exp)
// ****************************************************************
`define TMR_CKS_FALL    3'h0
`define TMR_CKS_RISE    3'h1
`define TMR_PRE_W       13
`define TMR_C0_EXP2     4'h0
`define TMR_C0_EXP3     4'h1
`define TMR_C0_EXP4     4'h2
`define TMR_C0_EXP5     4'h6
`define TMR_C0_EXP6     4'h8
`define TMR_C0_EXP7     4'hD
`define TMR_C1_EXP2     4'h0
`define TMR_C1_EXP3     4'h1
`define TMR_C1_EXP4     4'h4
`define TMR_C1_EXP5     4'h6
`define TMR_C1_EXP6     4'h8
`define TMR_C1_EXP7     4'hC

`endif

// ==== verilog/pin_edge_sync.v ====
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes the pin is asynchronous to mclk; pulses are one mclk wide
`timescale 1ns/1ps

module pin_edge_sync (
    input  wire mclk,
    input  wire nrst,
    input  wire pin_async,
    output wire rise,
    output wire fall
);

    reg s1_ff;
    reg s2_ff;
    reg s3_ff;
    reg level_ff;

    // ****************************************************************
    // synchroniser chain and filtered level
    // ****************************************************************
    // the level follows only when stages two and three agree
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
        end else begin
            s1_ff <= pin_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end

    // edge pulses from the agreed level against the held one
    assign rise = (s2_ff == s3_ff) & s3_ff & ~level_ff;
    assign fall = (s2_ff == s3_ff) & ~s3_ff & level_ff;

endmodule

// ==== verilog/timer8_pair.v ====
// two 8-bit timer/event counters with their clock select, compare and
// mode registers, the shared pin port registers and the pin muxing
// assumes a cpu store/load port on mclk: addr valid with wr_en or rd_en
`timescale 1ns/1ps
`include "timer8_defs.vh"

module timer8_pair (
    input  wire        mclk,
    input  wire        nrst,
    input  wire [15:0] addr,
    input  wire        wr_en,
    input  wire [7:0]  wr_data,
    input  wire        rd_en,
    output reg  [7:0]  rd_data_ff,
    output wire [1:0]  match_irq,
    input  wire [1:0]  pin_in,
    output wire [1:0]  pin_out,
    output wire [1:0]  pin_oe_n
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    reg  [`TMR_PRE_W-1:0] pre_ff;
    reg  [7:0]            pdir1_ff;
    reg  [3:0]            pdir3_ff;
    reg  [7:0]            plat1_ff;
    reg  [3:0]            plat3_ff;
    reg  [7:0]            nxt_rd_data;
    wire [`TMR_PRE_W:0]   all_ones;
    wire [1:0]            ev_rise;
    wire [1:0]            ev_fall;
    wire [5:0]            cks_w;
    wire [15:0]           cmp_w;
    wire [15:0]           mode_w;
    wire [15:0]           cnt_w;
    wire [1:0]            level_w;
    wire [1:0]            pin_dir;
    wire [1:0]            pin_lat;

    // ****************************************************************
    // prescaler from the main oscillator clock
    // ****************************************************************
    // free-running divider; all_ones[k] marks one cycle in every 2**k
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre_ff <= {`TMR_PRE_W{1'b0}};
        end else begin
            pre_ff <= pre_ff + {{(`TMR_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // tap zero is every cycle, the undivided clock selection
    assign all_ones[0] = 1'b1;

    genvar j;
    generate
        for (j = 1; j <= `TMR_PRE_W; j = j + 1) begin : g_ones
            assign all_ones[j] = all_ones[j-1] & pre_ff[j-1];
        end
    endgenerate

    // prescaler exponent for a clock select code and a channel
    function [3:0] pick_exp;
        input [2:0] sel;
        input       ch;
        begin
            pick_exp = 4'h0;
            case (sel)
                3'h2:    pick_exp = ch ? `TMR_C1_EXP2 : `TMR_C0_EXP2;
                3'h3:    pick_exp = ch ? `TMR_C1_EXP3 : `TMR_C0_EXP3;
                3'h4:    pick_exp = ch ? `TMR_C1_EXP4 : `TMR_C0_EXP4;
                3'h5:    pick_exp = ch ? `TMR_C1_EXP5 : `TMR_C0_EXP5;
                3'h6:    pick_exp = ch ? `TMR_C1_EXP6 : `TMR_C0_EXP6;
                3'h7:    pick_exp = ch ? `TMR_C1_EXP7 : `TMR_C0_EXP7;
                default: pick_exp = 4'h0;
            endcase
        end
    endfunction

    // ****************************************************************
    // port direction and port latch registers
    // ****************************************************************
    // direction resets to input; port 3 upper nibble is fixed at one
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pdir1_ff <= `TMR_RST_PDIR;
            pdir3_ff <= `TMR_RST_PDIR3;
            plat1_ff <= `TMR_RST_PLAT;
            plat3_ff <= `TMR_RST_PLAT3;
        end else if (wr_en) begin
            if (addr == `TMR_ADDR_PDIR1) begin
                pdir1_ff <= wr_data;
            end
            if (addr == `TMR_ADDR_PDIR3) begin
                pdir3_ff <= wr_data[3:0];
            end
            if (addr == `TMR_ADDR_PLAT1) begin
                plat1_ff <= wr_data;
            end
            if (addr == `TMR_ADDR_PLAT3) begin
                plat3_ff <= wr_data[3:0];
            end
        end
    end

    // pin 0 sits on port 1 bit 7, pin 1 on port 3 bit 3
    assign pin_dir = {pdir3_ff[`TMR_PIN1_BIT], pdir1_ff[`TMR_PIN0_BIT]};
    assign pin_lat = {plat3_ff[`TMR_PIN1_BIT], plat1_ff[`TMR_PIN0_BIT]};

    // ****************************************************************
    // per-counter logic
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            reg  [2:0] cks_ff;
            reg  [7:0] cmp_ff;
            reg  [3:0] mode_ff;        // run, pwm, toggle/polarity, enable
            reg  [7:0] cnt_ff;
            reg        out_ff;
            reg        pwm_ff;
            reg        irq_ff;
            wire       wr_cks;
            wire       wr_cmp;
            wire       wr_mode;
            wire       run;
            wire       pwm;
            wire       togpol;
            wire       oen;
            wire       tick;
            wire       hit;
            wire       pwm_level;

            // address decode for this counter
            assign wr_cks  = wr_en & (addr == (i ? `TMR_ADDR_CKS1 : `TMR_ADDR_CKS0));
            assign wr_cmp  = wr_en & (addr == (i ? `TMR_ADDR_CMP1 : `TMR_ADDR_CMP0));
            assign wr_mode = wr_en & (addr == (i ? `TMR_ADDR_MODE1 : `TMR_ADDR_MODE0));

            // stored mode bits; pwm, enable and pwm polarity act on the pin at once, run only through the registered counter, output ff and pwm ff
            assign run    = mode_ff[3];
            assign pwm    = mode_ff[2];
            assign togpol = mode_ff[1];
            assign oen    = mode_ff[0];

            // event pin conditioning
            pin_edge_sync u_sync (
                .mclk      (mclk),
                .nrst      (nrst),
                .pin_async (pin_in[i]),
                .rise      (ev_rise[i]),
                .fall      (ev_fall[i])
            );

            // count clock select: pin edges or prescaler taps
            assign tick = (cks_ff == `TMR_CKS_FALL) ? ev_fall[i] :
                          (cks_ff == `TMR_CKS_RISE) ? ev_rise[i] :
                          all_ones[pick_exp(cks_ff, i[0])];

            // compare is continuous; a match only counts on a tick
            assign hit = (cnt_ff == cmp_ff);

            // configuration registers; only low three select bits kept
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    cks_ff  <= `TMR_RST_CKS;
                    cmp_ff  <= `TMR_RST_CMP;
                    mode_ff <= `TMR_RST_MODEB;
                end else begin
                    if (wr_cks) begin
                        cks_ff <= wr_data[`TMR_CKS_MSB:0];
                    end
                    if (wr_cmp) begin
                        cmp_ff <= wr_data;
                    end
                    if (wr_mode) begin
                        mode_ff <= {wr_data[`TMR_RUN_BIT], wr_data[`TMR_PWM_BIT],
                                    wr_data[`TMR_TOGPOL_BIT], wr_data[`TMR_OEN_BIT]};
                    end
                end
            end

            // up counter: clear on stop, clear on match in clear mode
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    cnt_ff <= `TMR_RST_CNT;
                    irq_ff <= 1'b0;
                end else if (!run) begin
                    cnt_ff <= `TMR_RST_CNT;
                    irq_ff <= 1'b0;
                end else if (tick) begin
                    irq_ff <= ~pwm & hit;
                    if (!pwm && hit) begin
                        cnt_ff <= `TMR_RST_CNT;
                    end else begin
                        cnt_ff <= cnt_ff + 8'h01;
                    end
                end else begin
                    irq_ff <= 1'b0;
                end
            end

            // timer output ff: software preset beats a same-cycle toggle
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    out_ff <= 1'b0;
                end else if (wr_mode && !pwm &&
                             (wr_data[`TMR_PSET_HI_BIT] ^ wr_data[`TMR_PSET_LO_BIT])) begin
                    out_ff <= wr_data[`TMR_PSET_HI_BIT];
                end else if (run && tick && !pwm && togpol && hit) begin
                    out_ff <= ~out_ff;
                end
            end

            // pwm ff: active from overflow, inactive at compare match
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pwm_ff <= 1'b0;
                end else if (!run || !pwm) begin
                    pwm_ff <= 1'b0;
                end else if (tick) begin
                    if (hit) begin
                        pwm_ff <= 1'b0;
                    end else if (cnt_ff == 8'hFF) begin
                        pwm_ff <= 1'b1;
                    end
                end
            end

            // polarity applied combinationally so settings act at once
            assign pwm_level  = pwm_ff ^ togpol;
            assign level_w[i] = oen & (pwm ? pwm_level : out_ff);

            assign cks_w[3*i+:3]  = cks_ff;
            assign cmp_w[8*i+:8]  = cmp_ff;
            assign cnt_w[8*i+:8]  = cnt_ff;
            assign mode_w[8*i+:8] = {mode_ff[3], mode_ff[2], 4'h0,
                                     mode_ff[1], mode_ff[0]};
            assign match_irq[i]   = irq_ff;

            // shared pin: timer level or-ed with the port latch
            assign pin_out[i]  = level_w[i] | pin_lat[i];
            assign pin_oe_n[i] = pin_dir[i];
        end
    endgenerate

    // ****************************************************************
    // register read path
    // ****************************************************************
    // unmapped addresses read as zero
    always @* begin
        nxt_rd_data = 8'h00;
        case (addr)
            `TMR_ADDR_CKS0:  nxt_rd_data = {5'h00, cks_w[2:0]};
            `TMR_ADDR_CKS1:  nxt_rd_data = {5'h00, cks_w[5:3]};
            `TMR_ADDR_CMP0:  nxt_rd_data = cmp_w[7:0];
            `TMR_ADDR_CMP1:  nxt_rd_data = cmp_w[15:8];
            `TMR_ADDR_MODE0: nxt_rd_data = mode_w[7:0] & `TMR_MODE_RMASK;
            `TMR_ADDR_MODE1: nxt_rd_data = mode_w[15:8] & `TMR_MODE_RMASK;
            `TMR_ADDR_CNT0:  nxt_rd_data = cnt_w[7:0];
            `TMR_ADDR_CNT1:  nxt_rd_data = cnt_w[15:8];
            `TMR_ADDR_PDIR1: nxt_rd_data = pdir1_ff;
            `TMR_ADDR_PDIR3: nxt_rd_data = `TMR_PDIR3_FIXED | {4'h0, pdir3_ff};
            `TMR_ADDR_PLAT1: nxt_rd_data = plat1_ff;
            `TMR_ADDR_PLAT3: nxt_rd_data = {4'h0, plat3_ff};
            default:         nxt_rd_data = 8'h00;
        endcase
    end

    // read data captured on the load strobe and held until the next one
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= 8'h00;
        end else if (rd_en) begin
            rd_data_ff <= nxt_rd_data;
        end
    end

endmodule

// ==== sim/pin_load_model.sv ====
// partner: event source on the two shared pins and the load beyond them
// assumes pin_oe_n low means the block drives the pin
`timescale 1ns/1ps

module pin_load_model (
    input  wire logic       mclk,
    input  wire logic [1:0] pin_out,
    input  wire logic [1:0] pin_oe_n,
    output logic      [1:0] pin_in
);
    logic [1:0] ev_ff = 2'h0;

    // pin level: block drive when enabled, else the event source
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ev_ff);

    // one event pulse, each level held ten clocks
    task automatic pulse(input int ch);
        repeat (10) @(posedge mclk);
        #1 ev_ff[ch] = 1'b1;
        repeat (10) @(posedge mclk);
        #1 ev_ff[ch] = 1'b0;
    endtask
endmodule

// ==== sim/timer8_pair_chk.sv ====
// checker for counter 0 and the pins of the dual timer block
// assumes it is bound to timer8_pair and sees only its ports
`timescale 1ns/1ps
`include "timer8_defs.vh"

module timer8_pair_chk (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [15:0] addr,
    input wire logic        wr_en,
    input wire logic [7:0]  wr_data,
    input wire logic        rd_en,
    input wire logic [7:0]  rd_data_ff,
    input wire logic [1:0]  match_irq,
    input wire logic [1:0]  pin_in,
    input wire logic [1:0]  pin_out,
    input wire logic [1:0]  pin_oe_n
);
    logic [7:0] mode0_ff;
    logic [7:0] cmp0_ff;
    logic [2:0] cks0_ff;
    logic       lat0_ff;
    logic       seen_ff;
    logic [8:0] gap_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // shadow of counter 0 registers, gap since the last match
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mode0_ff <= 8'h00;
            cmp0_ff  <= 8'h00;
            cks0_ff  <= 3'h0;
            lat0_ff  <= 1'b0;
            seen_ff  <= 1'b0;
            gap_ff   <= 9'h000;
        end else begin
            if (wr_en && addr == `TMR_ADDR_MODE0) mode0_ff <= wr_data;
            if (wr_en && addr == `TMR_ADDR_CMP0) cmp0_ff <= wr_data;
            if (wr_en && addr == `TMR_ADDR_CKS0) cks0_ff <= wr_data[2:0];
            if (wr_en && addr == `TMR_ADDR_PLAT1) lat0_ff <= wr_data[7];
            seen_ff <= wr_en ? 1'b0 : (match_irq[0] | seen_ff);
            gap_ff  <= match_irq[0] ? 9'h001 : gap_ff + 9'h001;
        end
    end

    sequence s_mode0_wr;
        wr_en && addr == `TMR_ADDR_MODE0;
    endsequence
    sequence s_stopped_wr;
        s_mode0_wr ##0 (!wr_data[7] && !mode0_ff[7] && !mode0_ff[6] && !wr_data[6]);
    endsequence

    AST_RST_DIR: assert property ($rose(nrst) |-> pin_oe_n == 2'b11)
        else $error("pin direction not input after reset");
    AST_DIR_WRITE: assert property (wr_en && addr == `TMR_ADDR_PDIR1 |=>
        pin_oe_n[0] == $past(wr_data[7])) else $error("pin direction not stored");
    AST_RD_MASK: assert property (rd_en && addr == `TMR_ADDR_MODE0 |=>
        rd_data_ff == ($past(mode0_ff) & `TMR_MODE_RMASK)) else $error("mode readback wrong");
    AST_OE_LOW: assert property (s_mode0_wr ##0 !wr_data[0] |=>
        pin_out[0] == lat0_ff) else $error("disabled output not low");
    AST_PRESET_SET: assert property (s_stopped_wr ##0 (wr_data[3:2] == 2'b10
        && wr_data[0]) ##1 !wr_en |-> ##1 pin_out[0]) else $error("preset set failed");
    AST_PRESET_CLR: assert property (s_stopped_wr ##0 (wr_data[3:2] == 2'b01
        && wr_data[0]) ##1 !wr_en |-> ##1 pin_out[0] == lat0_ff) else $error("preset clr failed");
    AST_PWM_IDLE: assert property (s_mode0_wr ##0 (!wr_data[7] && wr_data[6]
        && wr_data[0]) ##1 !wr_en |-> ##1 pin_out[0] == ($past(wr_data[1], 2) | lat0_ff))
        else $error("stopped pwm output not inactive");
    AST_IRQ_GAP: assert property (match_irq[0] && seen_ff && cks0_ff == 3'h2
        && !mode0_ff[6] |-> gap_ff == {1'b0, cmp0_ff} + 9'h001) else $error("match period wrong");
endmodule

bind timer8_pair timer8_pair_chk u_chk (.mclk(mclk), .nrst(nrst), .addr(addr),
    .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en), .rd_data_ff(rd_data_ff),
    .match_irq(match_irq), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));

// ==== sim/timer8_pair_bench.sv ====
// self-checking bench for the dual 8-bit timer block
// assumes the pin load model and the bound checker beside it
`timescale 1ns/1ps
`include "timer8_defs.vh"

module timer8_pair_bench;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic        wr_en = 1'b0;
    logic [7:0]  wr_data = 8'h00;
    logic        rd_en = 1'b0;
    logic [7:0]  rd_data_ff;
    logic [1:0]  match_irq;
    logic [1:0]  pin_in;
    logic [1:0]  pin_out;
    logic [1:0]  pin_oe_n;
    logic [7:0]  d;
    logic [15:0] ma;
    logic        lv;
    int          mismatches = 0;
    int          comparisons = 0;
    int          n;
    int          i;
    int          ch;
    int          exp0[6] = '{0, 1, 2, 6, 8, 13};
    int          exp1[6] = '{0, 1, 4, 6, 8, 12};
    logic [15:0] regs[12] = '{`TMR_ADDR_CKS0, `TMR_ADDR_CKS1, `TMR_ADDR_CMP0, `TMR_ADDR_CMP1,
        `TMR_ADDR_MODE0, `TMR_ADDR_MODE1, `TMR_ADDR_CNT0, `TMR_ADDR_CNT1, `TMR_ADDR_PDIR1,
        `TMR_ADDR_PDIR3, `TMR_ADDR_PLAT1, 16'h1234};
    logic [7:0]  rstv[12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hFF, 8'hFF, 8'h00, 8'h00};

    timer8_pair u_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data_ff(rd_data_ff), .match_irq(match_irq),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    pin_load_model u_pin (.mclk(mclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

    // 125 MHz clock
    always #4 mclk = ~mclk;

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        comparisons++;
        if (seen !== expd) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        #1;
        addr = a;
        wr_data = v;
        wr_en = 1'b1;
        @(posedge mclk);
        #1;
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge mclk);
        #1;
        rd_en = 1'b0;
        v = rd_data_ff;
    endtask
    task automatic wait_irq(input int c, output int cyc);
        cyc = 0;
        do begin
            @(posedge mclk);
            #1;
            cyc++;
        end while (match_irq[c] !== 1'b1 && cyc < 20000);
        if (cyc >= 20000) begin
            check(16'h0000, 16'h0001);
            print_verdict();
        end
    endtask
    task automatic count_high(output int h);
        h = 0;
        repeat (256) begin
            @(posedge mclk);
            #1;
            h += pin_out[0];
        end
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        #1 nrst = 1'b1;
        // reset values, an unmapped place included
        for (i = 0; i < 12; i++) begin
            rd(regs[i], d);
            check(16'(d), 16'(rstv[i]));
        end
        check(16'(pin_oe_n), 16'h0003);
        $display("test reset values done");
        // readback, write-only preset bits, read-only counter
        wr(`TMR_ADDR_CMP1, 8'hA5);
        rd(`TMR_ADDR_CMP1, d);
        check(16'(d), 16'h00A5);
        wr(`TMR_ADDR_MODE1, 8'h4A);
        rd(`TMR_ADDR_MODE1, d);
        check(16'(d), 16'h0042);
        wr(`TMR_ADDR_MODE1, 8'h01);
        wr(`TMR_ADDR_MODE1, 8'h05);
        check(16'(pin_out[1]), 16'h0000);
        wr(`TMR_ADDR_MODE1, 8'h09);
        check(16'(pin_out[1]), 16'h0001);
        wr(`TMR_ADDR_MODE1, 8'h00);
        wr(`TMR_ADDR_CNT0, 8'h5A);
        rd(`TMR_ADDR_CNT0, d);
        check(16'(d), 16'h0000);
        $display("test register access done");
        // square wave on counter 0 with presets
        wr(`TMR_ADDR_PDIR1, 8'h7F);
        wr(`TMR_ADDR_CKS0, 8'h02);
        wr(`TMR_ADDR_CMP0, 8'h03);
        wr(`TMR_ADDR_MODE0, 8'h02);
        check(16'(pin_out[0]), 16'h0000);
        wr(`TMR_ADDR_MODE0, 8'h03);
        wr(`TMR_ADDR_MODE0, 8'h0B);
        @(posedge mclk);
        #1 check(16'(pin_out[0]), 16'h0001);
        rd(`TMR_ADDR_MODE0, d);
        check(16'(d), 16'h0003);
        wr(`TMR_ADDR_MODE0, 8'h07);
        @(posedge mclk);
        #1 check(16'(pin_out[0]), 16'h0000);
        wr(`TMR_ADDR_MODE0, 8'h0B);
        wr(`TMR_ADDR_MODE0, 8'h83);
        wait_irq(0, n);
        lv = pin_out[0];
        wait_irq(0, n);
        check(16'(n), 16'h0004);
        check(16'(pin_out[0] ^ lv), 16'h0001);
        wr(`TMR_ADDR_MODE0, 8'h03);
        rd(`TMR_ADDR_CNT0, d);
        check(16'(d), 16'h0000);
        $display("test square wave done");
        // every timed clock select code on both counters
        wr(`TMR_ADDR_CMP0, 8'h00);
        wr(`TMR_ADDR_CMP1, 8'h00);
        for (i = 0; i < 6; i++) begin
            for (ch = 0; ch < 2; ch++) begin
                ma = ch ? `TMR_ADDR_MODE1 : `TMR_ADDR_MODE0;
                wr(ma, 8'h00);
                wr(ch ? `TMR_ADDR_CKS1 : `TMR_ADDR_CKS0, 8'(i + 2));
                wr(ma, 8'h80);
                wait_irq(ch, n);
                wait_irq(ch, n);
                check(16'(n), 16'(1 << (ch ? exp1[i] : exp0[i])));
            end
        end
        wr(`TMR_ADDR_MODE0, 8'h00);
        $display("test clock select done");
        // event edges on both counters, falling then rising
        wr(`TMR_ADDR_PDIR1, 8'hFF);
        for (i = 0; i < 4; i++) begin
            ch = i / 2;
            ma = ch ? `TMR_ADDR_MODE1 : `TMR_ADDR_MODE0;
            wr(ma, 8'h00);
            wr(ch ? `TMR_ADDR_CMP1 : `TMR_ADDR_CMP0, 8'h05);
            wr(ch ? `TMR_ADDR_CKS1 : `TMR_ADDR_CKS0, 8'(i % 2));
            wr(ma, 8'h80);
            u_pin.pulse(ch);
            u_pin.pulse(ch);
            repeat (6) @(posedge mclk);
            rd(ch ? `TMR_ADDR_CNT1 : `TMR_ADDR_CNT0, d);
            check(16'(d), 16'h0002);
            wr(ma, 8'h00);
        end
        $display("test event count done");
        // pwm duty, ignored preset, stop and polarity
        wr(`TMR_ADDR_CKS0, 8'h02);
        wr(`TMR_ADDR_CMP0, 8'h40);
        wr(`TMR_ADDR_MODE0, 8'h40);
        wr(`TMR_ADDR_MODE0, 8'h41);
        wr(`TMR_ADDR_MODE0, 8'hC1);
        repeat (260) @(posedge mclk);
        count_high(n);
        check(16'(n), 16'h0041);
        wr(`TMR_ADDR_MODE0, 8'hC9);
        count_high(n);
        check(16'(n), 16'h0041);
        wr(`TMR_ADDR_CMP0, 8'h20);
        repeat (260) @(posedge mclk);
        count_high(n);
        check(16'(n), 16'h0021);
        wr(`TMR_ADDR_MODE0, 8'h41);
        repeat (2) @(posedge mclk);
        #1 check(16'(pin_out[0]), 16'h0000);
        wr(`TMR_ADDR_MODE0, 8'h43);
        check(16'(pin_out[0]), 16'h0001);
        $display("test pwm done");
        print_verdict();
    end
endmodule
